// ===== include/swdc_pkg.sv
// package: constants, command codes and carrier types for the single-wire debug command port
package swdc_pkg;

  // link timing in debug clock cycles (the block runs on the debug clock, 25 MHz)
  localparam logic [7:0] RX_SAMPLE_CYC  = 8'h0A;  // host-to-target bit sample point
  localparam logic [7:0] BIT0_LOW_CYC   = 8'h0D;  // low time for a returned zero
  localparam logic [7:0] SYNC_MIN_CYC   = 8'h80;  // host low longer than this is a sync request
  localparam logic [7:0] SYNC_GAP_CYC   = 8'h10;  // quiet time before the reference pulse
  localparam logic [7:0] SYNC_PULSE_CYC = 8'h80;  // reference pulse low time
  localparam logic [7:0] ACK_LOW_CYC    = 8'h10;  // acknowledge pulse low time
  localparam logic [7:0] DELAY_CYC      = 8'h10;  // internal access window for a delay field
  localparam logic [7:0] CNT_MAX        = 8'hFF;

  // status/control byte layout
  localparam int unsigned ST_HALT_ALLOW = 7;
  localparam int unsigned ST_HALTED     = 6;
  localparam int unsigned ST_ACK_EN     = 5;

  localparam logic [4:0] TX_BYTE = 5'h08;
  localparam logic [4:0] TX_WORD = 5'h10;
  localparam logic [15:0] BRK_RESET = 16'h0000;

  // command codes
  localparam logic [7:0] CMD_ACK_ON     = 8'hD5;
  localparam logic [7:0] CMD_ACK_OFF    = 8'hD6;
  localparam logic [7:0] CMD_BG_ENTER   = 8'h90;
  localparam logic [7:0] CMD_GET_STAT   = 8'hE4;
  localparam logic [7:0] CMD_SET_CTRL   = 8'hC4;
  localparam logic [7:0] CMD_MEM_RD     = 8'hE0;
  localparam logic [7:0] CMD_MEM_RD_ST  = 8'hE1;  // mem_rd_stat_cmd
  localparam logic [7:0] CMD_RD_LAST    = 8'hE8;
  localparam logic [7:0] CMD_MEM_WR     = 8'hC0;
  localparam logic [7:0] CMD_MEM_WR_ST  = 8'hC1;  // mem_wr_stat_cmd
  localparam logic [7:0] CMD_GET_BRK    = 8'hE2;  // get_brk_addr_cmd
  localparam logic [7:0] CMD_SET_BRK    = 8'hC2;  // set_brk_addr_cmd
  localparam logic [7:0] CMD_RESUME     = 8'h08;
  localparam logic [7:0] CMD_STEP       = 8'h10;  // single_step_cmd
  localparam logic [7:0] CMD_RESUME_TAG = 8'h18;  // resume_tagged_cmd
  localparam logic [7:0] CMD_GET_ACC    = 8'h68;
  localparam logic [7:0] CMD_GET_FLAGS  = 8'h69;
  localparam logic [7:0] CMD_GET_PC     = 8'h6B;
  localparam logic [7:0] CMD_GET_INDEX  = 8'h6C;
  localparam logic [7:0] CMD_GET_SP     = 8'h6F;
  localparam logic [7:0] CMD_INC_RD     = 8'h70;
  localparam logic [7:0] CMD_INC_RD_ST  = 8'h71;
  localparam logic [7:0] CMD_SET_ACC    = 8'h48;
  localparam logic [7:0] CMD_SET_FLAGS  = 8'h49;
  localparam logic [7:0] CMD_SET_PC     = 8'h4B;
  localparam logic [7:0] CMD_SET_INDEX  = 8'h4C;
  localparam logic [7:0] CMD_SET_SP     = 8'h4F;
  localparam logic [7:0] CMD_INC_WR     = 8'h50;
  localparam logic [7:0] CMD_INC_WR_ST  = 8'h51;

  typedef enum logic [2:0] {
    CR_ACC   = 3'h0,
    CR_FLAGS = 3'h1,
    CR_PC    = 3'h2,
    CR_INDEX = 3'h3,
    CR_SP    = 3'h4
  } swdc_cpu_reg_t;

  typedef struct packed {
    logic        halted;
    logic [7:0]  acc;
    logic [7:0]  flags;
    logic [15:0] pc;
    logic [15:0] index;
    logic [15:0] sp;
  } swdc_cpu_view_t;

  typedef struct packed {
    logic          bg_req;
    logic          go;
    logic          step;
    logic          tag_en;
    logic          wr_en;
    swdc_cpu_reg_t wr_sel;
    logic [15:0]   wr_data;
  } swdc_cpu_ctl_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } swdc_mem_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } swdc_mem_rsp_t;

  typedef struct packed {
    logic       known;
    logic       bg_only;
    logic       has_delay;
    logic [1:0] rx_n;
  } swdc_cmd_info_t;

  // command attributes: argument bytes, delay field, background-only class
  function automatic swdc_cmd_info_t cmd_info(input logic [7:0] c);
    swdc_cmd_info_t i;
    i = '{known: 1'b1, bg_only: 1'b0, has_delay: 1'b0, rx_n: 2'h0};
    unique case (c)
      CMD_ACK_ON, CMD_ACK_OFF, CMD_BG_ENTER: i.has_delay = 1'b1;
      CMD_GET_STAT, CMD_GET_BRK, CMD_RD_LAST: ;
      CMD_SET_CTRL: i.rx_n = 2'h1;
      CMD_SET_BRK: i.rx_n = 2'h2;
      CMD_MEM_RD, CMD_MEM_RD_ST: begin
        i.rx_n = 2'h2;
        i.has_delay = 1'b1;
      end
      CMD_MEM_WR, CMD_MEM_WR_ST: begin
        i.rx_n = 2'h3;
        i.has_delay = 1'b1;
      end
      CMD_RESUME, CMD_STEP, CMD_RESUME_TAG, CMD_GET_ACC, CMD_GET_FLAGS, CMD_GET_PC,
      CMD_GET_INDEX, CMD_GET_SP, CMD_INC_RD, CMD_INC_RD_ST: begin
        i.bg_only = 1'b1;
        i.has_delay = 1'b1;
      end
      CMD_SET_ACC, CMD_SET_FLAGS, CMD_INC_WR, CMD_INC_WR_ST: begin
        i.bg_only = 1'b1;
        i.has_delay = 1'b1;
        i.rx_n = 2'h1;
      end
      CMD_SET_PC, CMD_SET_INDEX, CMD_SET_SP: begin
        i.bg_only = 1'b1;
        i.has_delay = 1'b1;
        i.rx_n = 2'h2;
      end
      default: i.known = 1'b0;
    endcase
    return i;
  endfunction

endpackage

// ===== design/swdc_debug_port.sv
// single-wire debug command port: receive fifo and target-side link and command engine
`timescale 1ns/1ps

// byte fifo between the bit receiver and the command decoder
module swdc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } swdc_fifo_st_t;

  swdc_fifo_st_t s_r;
  swdc_fifo_st_t s_nxt;
  logic          push;
  logic          pop;

  // honest full and empty from the occupancy count
  assign in_ready  = (s_r.cnt != DEPTH_CNT);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and storage update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// Notes on behaviour
// - every bit time starts with a host falling edge; the target finishes the bit
// - target tolerates zero to one clock of skew between host edge and bit start
// - a returned zero is 13 clocks low, then one brief high speed-up drive
// - long host low is a sync request; target answers with a timed reference pulse
// - 0xD5 enables and 0xD6 disables the acknowledge pulse, CPU need not halt
// - 0x90 requests background entry only when the halt-allow bit is set
// - 0xE4 returns the status/control byte, 0xC4 writes only its halt-allow bit, CPU may run
// - 0xE0 reads a memory byte after a delay; 0xE1 sends status first
// - 0xE8 returns status then a fresh read of the last read address
// - 0xC0 writes a memory byte then delays; 0xC1 also returns status
// - 0xE2 returns the break register, 0xC2 loads it, CPU may run
// - 0x08 in background mode resumes the user program at the current counter
// - 0x10 in background mode runs one instruction then returns to background
// - 0x18 acts as resume and also sets the tag enable output, which then stays set until reset
// - in background, 0x68 and 0x69 return accumulator and flags after a delay
// - in background, 0x6B, 0x6C, 0x6F return program counter, index, stack pointer
// - in background, 0x48 and 0x49 load accumulator and flags, then delay
// - in background, 0x4B, 0x4C, 0x4F load program counter, index, stack pointer
// - 0x70 increments index then reads that byte; 0x71 adds status first
// - 0x50 increments index then writes that byte; 0x51 then returns status
module swdc_debug_port #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    debug_pin_in,
  output logic                         debug_pin_out,
  output logic                         debug_pin_oe,
  input  wire swdc_pkg::swdc_cpu_view_t cpu_view,
  output swdc_pkg::swdc_cpu_ctl_t      cpu_ctl,
  output swdc_pkg::swdc_mem_req_t      mem_req,
  input  wire swdc_pkg::swdc_mem_rsp_t mem_rsp,
  output logic [15:0]                  debug_break_reg
);
  import swdc_pkg::*;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'h0,
    LK_BIT   = 3'h1,
    LK_TXLOW = 3'h2,
    LK_SPEED = 3'h3,
    LK_SYNCW = 3'h4,
    LK_GAP   = 3'h5,
    LK_PULSE = 3'h6
  } swdc_link_t;

  typedef enum logic [2:0] {
    DEC_IDLE = 3'h0,
    DEC_ARG  = 3'h1,
    DEC_EXEC = 3'h2,
    DEC_MEM  = 3'h3,
    DEC_DONE = 3'h4,
    DEC_SEND = 3'h5
  } swdc_dec_t;

  typedef struct packed {
    logic           sync1;
    logic           sync2;
    logic           sync3;
    swdc_link_t     lk;
    logic [7:0]     lk_cnt;
    logic [7:0]     lk_len;
    logic           lk_rx;
    logic [7:0]     rx_sh;
    logic [2:0]     rx_cnt;
    logic           rx_full;
    swdc_dec_t      dec;
    logic [7:0]     cmd;
    swdc_cmd_info_t info;
    logic [23:0]    arg;
    logic [1:0]     rx_need;
    logic [15:0]    tx_sh;
    logic [4:0]     tx_n;
    logic [7:0]     dly;
    logic           ack_pend;
    logic           ack_en;
    logic           halt_allow;
    logic           ws;
    logic [15:0]    last_addr;
    logic [15:0]    brk;
    logic           pin_out;
    logic           pin_oe;
    swdc_cpu_ctl_t  cpu;
    swdc_mem_req_t  mem;
  } swdc_state_t;

  swdc_state_t s_r;
  swdc_state_t s_nxt;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [7:0]  f_out_data;

  // received bytes queue here; a full queue holds off further host bits
  swdc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (s_r.rx_full),
    .in_ready  (f_in_ready),
    .in_data   (s_r.rx_sh),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // decoder drains the queue only while collecting command bytes
  assign f_out_ready = (s_r.dec == DEC_IDLE) || (s_r.dec == DEC_ARG);

  assign debug_pin_out   = s_r.pin_out;
  assign debug_pin_oe    = s_r.pin_oe;
  assign cpu_ctl         = s_r.cpu;
  assign mem_req         = s_r.mem;
  assign debug_break_reg = s_r.brk;

  // link engine and command decoder
  always_comb begin
    logic       fall;
    logic       lvl;
    logic       tx_mode;
    logic [7:0] status;
    logic [15:0] idx_inc;
    s_nxt = s_r;
    fall = s_r.sync3 && !s_r.sync2;
    lvl = s_r.sync2;
    tx_mode = (s_r.dec == DEC_SEND) && (s_r.tx_n != '0);
    status = '0;
    status[ST_HALT_ALLOW] = s_r.halt_allow;
    status[ST_HALTED] = cpu_view.halted;
    status[ST_ACK_EN] = s_r.ack_en;
    idx_inc = cpu_view.index + 16'h0001;
    s_nxt.cpu.bg_req = 1'b0;
    s_nxt.cpu.go = 1'b0;
    s_nxt.cpu.step = 1'b0;
    s_nxt.cpu.wr_en = 1'b0;

    // pin synchroniser, only the second stage onward is read
    s_nxt.sync1 = debug_pin_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;

    // completed byte leaves for the fifo when it has room
    if (s_r.rx_full && f_in_ready) begin
      s_nxt.rx_full = 1'b0;
    end

    // bit-level link sequencing
    unique case (s_r.lk)
      LK_IDLE: begin
        if (s_r.ack_pend) begin
          s_nxt.ack_pend = 1'b0;
          s_nxt.lk = LK_PULSE;
          s_nxt.lk_cnt = '0;
          s_nxt.lk_len = ACK_LOW_CYC;
          s_nxt.pin_out = 1'b0;
          s_nxt.pin_oe = 1'b1;
        end else if (fall && !s_r.rx_full) begin
          s_nxt.lk_cnt = 8'h01;
          s_nxt.lk_rx = !tx_mode;
          if (tx_mode) begin
            s_nxt.tx_sh = {s_r.tx_sh[14:0], 1'b0};
            s_nxt.tx_n = s_r.tx_n - 5'h01;
            if (!s_r.tx_sh[15]) begin
              s_nxt.lk = LK_TXLOW;
              s_nxt.pin_out = 1'b0;
              s_nxt.pin_oe = 1'b1;
            end else begin
              s_nxt.lk = LK_BIT;
            end
          end else begin
            s_nxt.lk = LK_BIT;
          end
        end
      end
      LK_BIT: begin
        if (s_r.lk_cnt != CNT_MAX) begin
          s_nxt.lk_cnt = s_r.lk_cnt + 8'h01;
        end
        if (s_r.lk_rx && s_r.lk_cnt == RX_SAMPLE_CYC) begin
          s_nxt.rx_sh = {s_r.rx_sh[6:0], lvl};
          s_nxt.rx_cnt = s_r.rx_cnt + 3'h1;
          if (s_r.rx_cnt == 3'h7) begin
            s_nxt.rx_full = 1'b1;
          end
        end
        if (lvl && s_r.lk_cnt > RX_SAMPLE_CYC) begin
          s_nxt.lk = LK_IDLE;
        end else if (!lvl && s_r.lk_cnt >= SYNC_MIN_CYC) begin
          s_nxt.lk = LK_SYNCW;
          s_nxt.rx_cnt = '0;
        end
      end
      LK_TXLOW: begin
        s_nxt.lk_cnt = s_r.lk_cnt + 8'h01;
        if (s_r.lk_cnt == BIT0_LOW_CYC) begin
          s_nxt.lk = LK_SPEED;
          s_nxt.pin_out = 1'b1;
        end
      end
      LK_SPEED: begin
        s_nxt.lk = LK_IDLE;
        s_nxt.pin_out = 1'b0;
        s_nxt.pin_oe = 1'b0;
      end
      LK_SYNCW: begin
        if (lvl) begin
          s_nxt.lk = LK_GAP;
          s_nxt.lk_cnt = '0;
        end
      end
      LK_GAP: begin
        s_nxt.lk_cnt = s_r.lk_cnt + 8'h01;
        if (s_r.lk_cnt == SYNC_GAP_CYC) begin
          s_nxt.lk = LK_PULSE;
          s_nxt.lk_cnt = '0;
          s_nxt.lk_len = SYNC_PULSE_CYC;
          s_nxt.pin_out = 1'b0;
          s_nxt.pin_oe = 1'b1;
        end
      end
      LK_PULSE: begin
        s_nxt.lk_cnt = s_r.lk_cnt + 8'h01;
        if (s_r.lk_cnt == s_r.lk_len) begin
          s_nxt.lk = LK_SPEED;
          s_nxt.pin_out = 1'b1;
        end
      end
      default: begin
        s_nxt.lk = LK_IDLE;
        s_nxt.pin_oe = 1'b0;
      end
    endcase

    // command decoding and execution
    unique case (s_r.dec)
      DEC_IDLE: begin
        if (f_out_valid) begin
          s_nxt.cmd = f_out_data;
          s_nxt.info = cmd_info(f_out_data);
          s_nxt.rx_need = s_nxt.info.rx_n;
          s_nxt.arg = '0;
          s_nxt.dly = '0;
          if (s_nxt.info.known) begin
            s_nxt.dec = (s_nxt.info.rx_n == 2'h0) ? DEC_EXEC : DEC_ARG;
          end
        end
      end
      DEC_ARG: begin
        if (f_out_valid) begin
          s_nxt.arg = {s_r.arg[15:0], f_out_data};
          s_nxt.rx_need = s_r.rx_need - 2'h1;
          if (s_r.rx_need == 2'h1) begin
            s_nxt.dec = DEC_EXEC;
          end
        end
      end
      DEC_EXEC: begin
        s_nxt.dec = DEC_DONE;
        s_nxt.tx_n = '0;
        s_nxt.ws = 1'b0;
        if (s_r.info.bg_only && !cpu_view.halted) begin
          s_nxt.dec = DEC_IDLE;
        end else begin
          unique case (s_r.cmd)
            CMD_ACK_ON: s_nxt.ack_en = 1'b1;
            CMD_ACK_OFF: s_nxt.ack_en = 1'b0;
            CMD_BG_ENTER: s_nxt.cpu.bg_req = s_r.halt_allow;
            CMD_GET_STAT: begin
              s_nxt.tx_sh = {status, 8'h00};
              s_nxt.tx_n = TX_BYTE;
            end
            CMD_SET_CTRL: s_nxt.halt_allow = s_r.arg[ST_HALT_ALLOW];
            CMD_MEM_RD, CMD_MEM_RD_ST, CMD_RD_LAST: begin
              s_nxt.ws = (s_r.cmd != CMD_MEM_RD);
              s_nxt.mem.addr = (s_r.cmd == CMD_RD_LAST) ? s_r.last_addr : s_r.arg[15:0];
              s_nxt.last_addr = (s_r.cmd == CMD_RD_LAST) ? s_r.last_addr : s_r.arg[15:0];
              s_nxt.mem.we = 1'b0;
              s_nxt.mem.valid = 1'b1;
              s_nxt.dec = DEC_MEM;
            end
            CMD_MEM_WR, CMD_MEM_WR_ST: begin
              s_nxt.ws = (s_r.cmd == CMD_MEM_WR_ST);
              s_nxt.mem.addr = s_r.arg[23:8];
              s_nxt.mem.wdata = s_r.arg[7:0];
              s_nxt.mem.we = 1'b1;
              s_nxt.mem.valid = 1'b1;
              s_nxt.dec = DEC_MEM;
            end
            CMD_GET_BRK: begin
              s_nxt.tx_sh = s_r.brk;
              s_nxt.tx_n = TX_WORD;
            end
            CMD_SET_BRK: s_nxt.brk = s_r.arg[15:0];
            CMD_RESUME: s_nxt.cpu.go = 1'b1;
            CMD_STEP: s_nxt.cpu.step = 1'b1;
            CMD_RESUME_TAG: begin
              s_nxt.cpu.go = 1'b1;
              s_nxt.cpu.tag_en = 1'b1;
            end
            CMD_GET_ACC, CMD_GET_FLAGS: begin
              s_nxt.tx_sh = {(s_r.cmd == CMD_GET_ACC) ? cpu_view.acc : cpu_view.flags, 8'h00};
              s_nxt.tx_n = TX_BYTE;
            end
            CMD_GET_PC: begin
              s_nxt.tx_sh = cpu_view.pc;
              s_nxt.tx_n = TX_WORD;
            end
            CMD_GET_INDEX: begin
              s_nxt.tx_sh = cpu_view.index;
              s_nxt.tx_n = TX_WORD;
            end
            CMD_GET_SP: begin
              s_nxt.tx_sh = cpu_view.sp;
              s_nxt.tx_n = TX_WORD;
            end
            CMD_SET_ACC, CMD_SET_FLAGS: begin
              s_nxt.cpu.wr_en = 1'b1;
              s_nxt.cpu.wr_sel = (s_r.cmd == CMD_SET_ACC) ? CR_ACC : CR_FLAGS;
              s_nxt.cpu.wr_data = {8'h00, s_r.arg[7:0]};
            end
            CMD_SET_PC, CMD_SET_INDEX, CMD_SET_SP: begin
              s_nxt.cpu.wr_en = 1'b1;
              s_nxt.cpu.wr_sel = (s_r.cmd == CMD_SET_PC) ? CR_PC :
                                 (s_r.cmd == CMD_SET_INDEX) ? CR_INDEX : CR_SP;
              s_nxt.cpu.wr_data = s_r.arg[15:0];
            end
            CMD_INC_RD, CMD_INC_RD_ST, CMD_INC_WR, CMD_INC_WR_ST: begin
              s_nxt.cpu.wr_en = 1'b1;
              s_nxt.cpu.wr_sel = CR_INDEX;
              s_nxt.cpu.wr_data = idx_inc;
              s_nxt.ws = (s_r.cmd == CMD_INC_RD_ST) || (s_r.cmd == CMD_INC_WR_ST);
              s_nxt.mem.addr = idx_inc;
              s_nxt.mem.wdata = s_r.arg[7:0];
              s_nxt.mem.we = (s_r.cmd == CMD_INC_WR) || (s_r.cmd == CMD_INC_WR_ST);
              s_nxt.mem.valid = 1'b1;
              s_nxt.dec = DEC_MEM;
              if (!s_nxt.mem.we) begin
                s_nxt.last_addr = idx_inc;
              end
            end
            default: s_nxt.dec = DEC_IDLE;
          endcase
        end
      end
      DEC_MEM: begin
        if (mem_rsp.ack) begin
          s_nxt.mem.valid = 1'b0;
          s_nxt.dec = DEC_DONE;
          if (!s_r.mem.we) begin
            s_nxt.tx_sh = s_r.ws ? {status, mem_rsp.rdata} : {mem_rsp.rdata, 8'h00};
            s_nxt.tx_n = s_r.ws ? TX_WORD : TX_BYTE;
          end else if (s_r.ws) begin
            s_nxt.tx_sh = {status, 8'h00};
            s_nxt.tx_n = TX_BYTE;
          end
        end
      end
      DEC_DONE: begin
        s_nxt.dly = s_r.dly + 8'h01;
        if (!s_r.info.has_delay || s_r.dly >= DELAY_CYC) begin
          s_nxt.ack_pend = s_r.info.has_delay && s_r.ack_en;
          s_nxt.dec = DEC_SEND;
        end
      end
      DEC_SEND: begin
        if (s_r.tx_n == '0) begin
          s_nxt.dec = DEC_IDLE;
        end
      end
      default: s_nxt.dec = DEC_IDLE;
    endcase

    // a sync request abandons any command not waiting on memory
    if (s_r.lk == LK_BIT && s_nxt.lk == LK_SYNCW && s_r.dec != DEC_MEM) begin
      s_nxt.dec = DEC_IDLE;
      s_nxt.tx_n = '0;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
      s_r.sync3 <= 1'b1;
      s_r.brk <= BRK_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== bench/swdc_debug_port_properties.sv
// checker: pin timing, cpu control and memory handshake of the debug port
`timescale 1ns/1ps
module swdc_debug_port_chk
  import swdc_pkg::*;
(
  input wire logic           clock,
  input wire logic           sys_rst,
  input wire logic           debug_pin_out,
  input wire logic           debug_pin_oe,
  input wire swdc_cpu_view_t cpu_view,
  input wire swdc_cpu_ctl_t  cpu_ctl,
  input wire swdc_mem_req_t  mem_req,
  input wire swdc_mem_rsp_t  mem_rsp
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // every low drive lasts at least the 13-cycle zero time
  chk_low_min_len: assert property ($rose(debug_pin_oe) |-> !debug_pin_out[*8] ##1 !debug_pin_out[*5])
    else $error("pin low drive too short");
  chk_release_after_high: assert property ($fell(debug_pin_oe) |-> $past(debug_pin_out))
    else $error("pin released without speed-up high");
  chk_speedup_one: assert property (debug_pin_oe && debug_pin_out |=> !debug_pin_oe)
    else $error("speed-up high longer than one cycle");
  chk_go_pulse: assert property (cpu_ctl.go |=> !cpu_ctl.go)
    else $error("go not a single pulse");
  chk_go_halted: assert property (cpu_ctl.go |-> $past(cpu_view.halted))
    else $error("go while cpu running");
  chk_wr_halted: assert property (cpu_ctl.wr_en |-> $past(cpu_view.halted))
    else $error("register write while cpu running");
  chk_mem_hold: assert property (mem_req.valid && !mem_rsp.ack |=> mem_req.valid && $stable(mem_req.addr))
    else $error("memory request dropped before ack");
  chk_tag_sticky: assert property (cpu_ctl.tag_en |=> cpu_ctl.tag_en)
    else $error("tag enable cleared");
endmodule
bind swdc_debug_port swdc_debug_port_chk u_chk (.clock, .sys_rst, .debug_pin_out, .debug_pin_oe,
  .cpu_view, .cpu_ctl, .mem_req, .mem_rsp);

// ===== bench/swdc_host_pod.sv
// host debug pod model: starts every bit time on the shared pin
`timescale 1ns/1ps
module swdc_host_pod (
  input wire logic clock,
  input wire logic pin,
  output logic     drive_low
);
  initial drive_low = 1'b0;
  // bytes go out msb first; short low is a one, long low a zero
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clock) drive_low = 1'b1;
      repeat (b[i] ? 4 : 20) @(negedge clock);
      drive_low = 1'b0;
      repeat (b[i] ? 24 : 8) @(negedge clock);
    end
  endtask
  // hold the pin low well past the sync threshold, then release
  task sync_req;
    @(negedge clock) drive_low = 1'b1;
    repeat (140) @(negedge clock);
    drive_low = 1'b0;
  endtask
  // open a bit time, release, sample about 10 cycles in
  task recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clock) drive_low = 1'b1;
      repeat (4) @(negedge clock);
      drive_low = 1'b0;
      repeat (6) @(negedge clock);
      b[i] = pin;
      repeat (18) @(negedge clock);
    end
  endtask
endmodule

// ===== bench/tb_swdc_debug_port.sv
// testbench for the single-wire debug command port
`timescale 1ns/1ps
module tb_swdc_debug_port;
  import swdc_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, host_low, pin_oe, pin_out, ack_d = 1'b0;
  wire pin;
  swdc_cpu_view_t cv;
  swdc_cpu_ctl_t cc;
  swdc_mem_req_t mq;
  swdc_mem_rsp_t ms;
  logic [15:0] brk, wr_addr, steps = 16'h0000;
  logic [7:0] a, b, wr_data;
  int err_count = 0, checks_done = 0;
  // pull-up wire: low when host or target pulls it down
  assign pin = ~(host_low | (pin_oe & ~pin_out));
  swdc_host_pod u_host (.clock(clock), .pin(pin), .drive_low(host_low));
  swdc_debug_port u_dut (.clock(clock), .sys_rst(sys_rst), .debug_pin_in(pin), .debug_pin_out(pin_out),
    .debug_pin_oe(pin_oe), .cpu_view(cv), .cpu_ctl(cc), .mem_req(mq), .mem_rsp(ms), .debug_break_reg(brk));
  initial forever #20 clock = ~clock;
  initial begin
    cv = '0;
    cv.pc = 16'h12C3;
    cv.flags = 8'h3C;
    ms = '0;
  end
  // memory and cpu stand-ins, answering at the falling edge
  always @(negedge clock) begin
    ms.ack <= mq.valid & ~ms.ack & ~ack_d;
    ack_d <= ms.ack;
    ms.rdata <= mq.addr[7:0] ^ 8'h5A;
    if (mq.valid & mq.we) begin
      wr_addr <= mq.addr;
      wr_data <= mq.wdata;
    end
    if (cc.bg_req) cv.halted <= 1'b1;
    if (cc.go) cv.halted <= 1'b0;
    if (cc.wr_en && cc.wr_sel === CR_ACC) cv.acc <= cc.wr_data[7:0];
    if (cc.wr_en && cc.wr_sel === CR_INDEX) cv.index <= cc.wr_data;
    if (cc.step) steps <= steps + 16'h0001;
  end
  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tx(input logic [7:0] v);
    u_host.send_byte(v);
  endtask
  task pause;
    repeat (40) @(negedge clock);
  endtask
  task t_status;
    tx(CMD_BG_ENTER);
    pause;
    chk("halt refused", cv.halted, 16'h0000);
    tx(CMD_SET_ACC);
    tx(8'h77);
    pause;
    chk("acc untouched", cv.acc, 16'h0000);
    tx(CMD_SET_CTRL);
    tx(8'h80);
    tx(CMD_GET_STAT);
    u_host.recv_byte(a);
    chk("status", a, 16'h0080);
    tx(CMD_BG_ENTER);
    pause;
    chk("halted", cv.halted, 16'h0001);
  endtask
  task t_mem;
    tx(CMD_MEM_RD);
    tx(8'h12);
    tx(8'h34);
    pause;
    u_host.recv_byte(a);
    chk("read", a, 16'h006E);
    tx(CMD_RD_LAST);
    u_host.recv_byte(a);
    u_host.recv_byte(b);
    chk("reread", {a, b}, 16'hC06E);
    tx(CMD_MEM_WR);
    tx(8'h56);
    tx(8'h78);
    tx(8'h9A);
    pause;
    chk("wr addr", wr_addr, 16'h5678);
    chk("wr data", wr_data, 16'h009A);
  endtask
  // sync reference pulse and acknowledge pulse, counted as target low-drive cycles
  task t_link;
    logic [15:0] n;
    n = 16'h0000;
    u_host.sync_req;
    repeat (200) @(negedge clock) n = n + (pin_oe & ~pin_out);
    chk("sync pulse", n, {8'h00, SYNC_PULSE_CYC} + 16'h0001);
    tx(CMD_ACK_ON);
    n = 16'h0000;
    repeat (60) @(negedge clock) n = n + (pin_oe & ~pin_out);
    chk("ack pulse", n, {8'h00, ACK_LOW_CYC} + 16'h0001);
    tx(CMD_ACK_OFF);
    n = 16'h0000;
    repeat (60) @(negedge clock) n = n + (pin_oe & ~pin_out);
    chk("ack off", n, 16'h0000);
  endtask
  task t_bg;
    tx(CMD_STEP);
    pause;
    chk("step", steps, 16'h0001);
    tx(CMD_GET_FLAGS);
    pause;
    u_host.recv_byte(a);
    chk("flags", a, 16'h003C);
    tx(CMD_SET_INDEX);
    tx(8'h20);
    tx(8'hFF);
    pause;
    chk("index", cv.index, 16'h20FF);
    tx(CMD_INC_RD_ST);
    pause;
    u_host.recv_byte(a);
    u_host.recv_byte(b);
    chk("inc read", {a, b}, 16'hC05A);
    tx(CMD_INC_WR);
    tx(8'h4D);
    pause;
    chk("inc wr addr", wr_addr, 16'h2101);
    chk("inc wr data", wr_data, 16'h004D);
  endtask
  task t_cpu;
    tx(CMD_GET_PC);
    pause;
    u_host.recv_byte(a);
    u_host.recv_byte(b);
    chk("pc", {a, b}, 16'h12C3);
    tx(CMD_SET_ACC);
    tx(8'h77);
    pause;
    chk("acc", cv.acc, 16'h0077);
    tx(CMD_RESUME_TAG);
    pause;
    chk("resumed", cv.halted, 16'h0000);
    chk("tag", cc.tag_en, 16'h0001);
  endtask
  task t_brk;
    tx(CMD_SET_BRK);
    tx(8'hAB);
    tx(8'hCD);
    pause;
    chk("brk port", brk, 16'hABCD);
    tx(CMD_GET_BRK);
    u_host.recv_byte(a);
    u_host.recv_byte(b);
    chk("brk read", {a, b}, 16'hABCD);
  endtask
  task conclude;
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    conclude;
  end
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (5) @(negedge clock);
    t_status;
    t_mem;
    t_link;
    t_bg;
    t_cpu;
    t_brk;
    conclude;
  end
endmodule
